//--- core/bgs_pkg.sv
// Constants shared by the board GPIO and boot strap latch design
// Notes on behaviour
// - Carrier LED bits light carrier LEDs; others unused
// - Input A bit 12 shows carrier interrupt
// - Input A bits 20-23 show four start buttons
// - Output B bits 8-15 drive card LEDs
// - Output B bits 23:16 drive seven segments
// - Input B bits 1-7 show card jumpers
// - Image switch 00 single, 01 dual core
// - Sample DIP banks in reset, capture at release
// - Latched switches initialise boot control bits
// - Right position gives 0, left gives 1
// - Boot mirror 00 disabled, 01 internal ROM
// - Cache-use bit readable, never changes hardware
// - Audio inputs held inactive at all times
// - Ports at 0x3000, 0x3050, 0x300C, 0x3054
package bgs_pkg;

  // Register byte offsets from the peripheral segment base
  localparam logic [15:0] OFS_CARRIER_LED_OUT  = 16'h3000;
  localparam logic [15:0] OFS_CARRIER_IN       = 16'h3050;
  localparam logic [15:0] OFS_CARD_OUT         = 16'h300C;
  localparam logic [15:0] OFS_CARD_IN          = 16'h3054;
  localparam logic [15:0] OFS_BOOT_CTRL        = 16'h3100;
  localparam logic [15:0] OFS_STRAP_STATUS     = 16'h3104;

  // Writable bit masks of the two output ports
  localparam logic [31:0] MASK_CARRIER_LED     = 32'h0001_8C63;
  localparam logic [31:0] MASK_CARD_OUT        = 32'h00FF_FF00;
  localparam int          CARRIER_LED_COUNT    = 8;
  localparam int          CARRIER_LED_BIT [8]  = '{0, 1, 5, 6, 10, 11, 15, 16};
  localparam int          CARD_LED_LSB         = 8;
  localparam int          SEGMENT_LSB          = 16;

  // Input port A and B bit positions
  localparam int          CARRIER_IRQ_BIT      = 12;
  localparam int          BTN_ONE_BIT          = 20;
  localparam int          BTN_THREE_BIT        = 21;
  localparam int          BTN_TWO_BIT          = 22;
  localparam int          BTN_FOUR_BIT         = 23;
  localparam int          JUMPER_LSB           = 1;
  localparam int          JUMPER_COUNT         = 7;

  // Boot control word: four DIP banks, eight switches each
  localparam int          DIP_BANKS            = 4;
  localparam int          BOOT_CFG_BANK        = 1;
  localparam int          BOOT_MIRROR_LSB      = 8 * BOOT_CFG_BANK;
  localparam int          CACHE_USE_BIT        = 8 * BOOT_CFG_BANK + 5;
  localparam logic [1:0]  BOOT_MIRROR_OFF      = 2'h0;
  localparam logic [1:0]  BOOT_MIRROR_ROM      = 2'h1;

  // Image select codes
  localparam logic [1:0]  IMAGE_SINGLE_CORE    = 2'h0;
  localparam logic [1:0]  IMAGE_DUAL_CORE      = 2'h1;

  // Strap status register fields
  localparam int          STAT_IMAGE_LSB       = 0;
  localparam int          STAT_DUAL_BIT        = 2;
  localparam int          STAT_IMAGE_RSVD_BIT  = 3;
  localparam int          STAT_MIRROR_ROM_BIT  = 4;
  localparam int          STAT_CACHE_USE_BIT   = 5;

  // Reset values
  localparam logic [31:0] RESET_PORT_VALUE     = 32'h0000_0000;

endpackage

//--- core/bgs_in_if.sv
// Interface carrying carrier and card input pins and the sampled port words
`timescale 1ns/10ps
`default_nettype none
interface bgs_in_if;
  logic        carrierIrq;
  logic [3:0]  startButtons;
  logic [6:0]  cardJumpers;
  logic [31:0] carrierInputSample;
  logic [31:0] cardJumperInput;

  modport top (output carrierIrq, output startButtons, output cardJumpers,
               input carrierInputSample, input cardJumperInput);
  modport sampler (input carrierIrq, input startButtons, input cardJumpers,
                   output carrierInputSample, output cardJumperInput);
endinterface
`default_nettype wire

//--- core/bgs_input_sampler.sv
// Samples carrier and card inputs into the two input port words
`timescale 1ns/10ps
`default_nettype none
module bgs_input_sampler
  import bgs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Pins and port words
  bgs_in_if.sampler inIf
);

  typedef struct packed {
    logic [31:0] portA;
    logic [31:0] portB;
  } bgs_samp_state_t;

  bgs_samp_state_t state_reg;
  bgs_samp_state_t state_next;

  always_comb begin
    state_next = '0;
    if (!srst) begin
      state_next.portA[CARRIER_IRQ_BIT] = inIf.carrierIrq;
      state_next.portA[BTN_ONE_BIT]     = inIf.startButtons[0];
      state_next.portA[BTN_TWO_BIT]     = inIf.startButtons[1];
      state_next.portA[BTN_THREE_BIT]   = inIf.startButtons[2];
      state_next.portA[BTN_FOUR_BIT]    = inIf.startButtons[3];
      state_next.portB[JUMPER_LSB +: JUMPER_COUNT] = inIf.cardJumpers;
    end
  end

  // All other bits stay zero so reserved bits read as zero
  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  assign inIf.carrierInputSample = state_reg.portA;
  assign inIf.cardJumperInput    = state_reg.portB;

endmodule
`default_nettype wire

//--- core/bgs_strap_latch.sv
// Captures DIP-switch banks and image select at the end of reset
`timescale 1ns/10ps
`default_nettype none
module bgs_strap_latch
  import bgs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Straps
  input  wire logic [31:0] dipBanks,
  input  wire logic [1:0]  imageSelectSwitch,
  // Latched values
  output logic      [31:0] strapWord,
  output logic      [1:0]  imageSelect
);

  typedef struct packed {
    logic [31:0] strapWord;
    logic [1:0]  imageSelect;
  } bgs_strap_state_t;

  bgs_strap_state_t state_reg;
  bgs_strap_state_t state_next;

  // Sampled on every edge while reset is high; the last edge holds
  always_comb begin
    state_next = state_reg;
    if (srst) begin
      state_next.strapWord   = dipBanks;
      state_next.imageSelect = imageSelectSwitch;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  assign strapWord   = state_reg.strapWord;
  assign imageSelect = state_reg.imageSelect;

endmodule
`default_nettype wire

//--- core/bgs_gpio_top.sv
// Board GPIO ports, boot control register and APB register slave
`timescale 1ns/10ps
`default_nettype none
module bgs_gpio_top
  import bgs_pkg::*;
#(
  parameter int         ADDR_WIDTH     = 16,
  parameter int         AUDIO_WIDTH    = 8,
  parameter logic [7:0] AUDIO_INACTIVE = 8'h00
)(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Carrier board pins
  output logic      [7:0]             carrierLeds,
  input  wire logic                   carrierIrq,
  input  wire logic [3:0]             startButtons,
  output logic      [AUDIO_WIDTH-1:0] audioInputs,
  // Card pins
  output logic      [7:0]             cardLeds,
  output logic      [7:0]             segmentDrive,
  input  wire logic [6:0]             cardJumpers,
  // Straps
  input  wire logic [31:0]            dipBanks,
  input  wire logic [1:0]             imageSelectSwitch,
  // Boot configuration towards the cores and loader
  output logic      [31:0]            bootControl,
  output logic                        bootMirrorRom,
  output logic      [1:0]             imageSelect,
  output logic                        dualCoreImage
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (ADDR_WIDTH < 16 || ADDR_WIDTH > 32) begin : g_addr_check
    $error("bgs_gpio_top: ADDR_WIDTH must be 16 to 32");
  end
  if (AUDIO_WIDTH < 1 || AUDIO_WIDTH > 8) begin : g_audio_check
    $error("bgs_gpio_top: AUDIO_WIDTH must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] carrierLedOutput;
    logic [31:0] cardLedSegmentOutput;
    logic [31:0] bootCtrl;
    logic [31:0] readData;
    logic        loadPending;
  } bgs_top_state_t;

  bgs_top_state_t state_reg;
  bgs_top_state_t state_next;

  bgs_in_if inIf ();

  logic [31:0] strapWord;
  logic [31:0] strapStatus;
  logic [15:0] offset;
  logic        setupPhase;
  logic        accessPhase;
  logic        addrHit;
  logic [31:0] byteMask;
  logic        upperZero;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  assign inIf.carrierIrq   = carrierIrq;
  assign inIf.startButtons = startButtons;
  assign inIf.cardJumpers  = cardJumpers;

  bgs_input_sampler u_sampler (
    .ref_clk (ref_clk),
    .srst    (srst),
    .inIf    (inIf)
  );

  bgs_strap_latch u_strap (
    .ref_clk           (ref_clk),
    .srst              (srst),
    .dipBanks          (dipBanks),
    .imageSelectSwitch (imageSelectSwitch),
    .strapWord         (strapWord),
    .imageSelect       (imageSelect)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign offset      = paddr[15:0];
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  if (ADDR_WIDTH > 16) begin : g_upper
    assign upperZero = (paddr[ADDR_WIDTH-1:16] == '0);
  end else begin : g_no_upper
    assign upperZero = 1'b1;
  end

  always_comb begin
    addrHit = 1'b0;
    if (!upperZero) begin
      addrHit = 1'b0;
    end else if (offset == OFS_CARRIER_LED_OUT) begin
      addrHit = 1'b1;
    end else if (offset == OFS_CARRIER_IN) begin
      addrHit = 1'b1;
    end else if (offset == OFS_CARD_OUT) begin
      addrHit = 1'b1;
    end else if (offset == OFS_CARD_IN) begin
      addrHit = 1'b1;
    end else if (offset == OFS_BOOT_CTRL) begin
      addrHit = 1'b1;
    end else if (offset == OFS_STRAP_STATUS) begin
      addrHit = 1'b1;
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_strobe
    assign byteMask[8*b +: 8] = {8{pstrb[b]}};
  end

  assign strapStatus = {26'h000_0000,
                        state_reg.bootCtrl[CACHE_USE_BIT],
                        bootMirrorRom,
                        imageSelect[1],
                        dualCoreImage,
                        imageSelect};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    if (srst) begin
      state_next.carrierLedOutput     = RESET_PORT_VALUE;
      state_next.cardLedSegmentOutput = RESET_PORT_VALUE;
      state_next.bootCtrl             = RESET_PORT_VALUE;
      state_next.readData             = RESET_PORT_VALUE;
      state_next.loadPending          = 1'b1;
    end else begin
      // Straps reach the control word on the first edge after release
      if (state_reg.loadPending) begin
        state_next.bootCtrl    = strapWord;
        state_next.loadPending = 1'b0;
      end
      // Read data is captured in setup so the access phase needs no wait
      if (setupPhase && !pwrite) begin
        state_next.readData = 32'h0000_0000;
        if (!upperZero) begin
          state_next.readData = 32'h0000_0000;
        end else if (offset == OFS_CARRIER_LED_OUT) begin
          state_next.readData = state_reg.carrierLedOutput;
        end else if (offset == OFS_CARRIER_IN) begin
          state_next.readData = inIf.carrierInputSample;
        end else if (offset == OFS_CARD_OUT) begin
          state_next.readData = state_reg.cardLedSegmentOutput;
        end else if (offset == OFS_CARD_IN) begin
          state_next.readData = inIf.cardJumperInput;
        end else if (offset == OFS_BOOT_CTRL) begin
          state_next.readData = state_reg.bootCtrl;
        end else if (offset == OFS_STRAP_STATUS) begin
          state_next.readData = strapStatus;
        end
      end
      if (accessPhase && pwrite && upperZero) begin
        if (offset == OFS_CARRIER_LED_OUT) begin
          state_next.carrierLedOutput = (state_reg.carrierLedOutput & ~(byteMask & MASK_CARRIER_LED))
                                      | (pwdata & byteMask & MASK_CARRIER_LED);
        end else if (offset == OFS_CARD_OUT) begin
          state_next.cardLedSegmentOutput = (state_reg.cardLedSegmentOutput & ~(byteMask & MASK_CARD_OUT))
                                          | (pwdata & byteMask & MASK_CARD_OUT);
        end else if (offset == OFS_BOOT_CTRL && !state_reg.loadPending) begin
          state_next.bootCtrl = (state_reg.bootCtrl & ~byteMask) | (pwdata & byteMask);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata  = state_reg.readData;
  assign pready  = 1'b1;
  assign pslverr = accessPhase && !addrHit;

  for (genvar i = 0; i < CARRIER_LED_COUNT; i++) begin : g_carrier_led
    assign carrierLeds[i] = state_reg.carrierLedOutput[CARRIER_LED_BIT[i]];
  end

  assign cardLeds     = state_reg.cardLedSegmentOutput[CARD_LED_LSB +: 8];
  assign segmentDrive = state_reg.cardLedSegmentOutput[SEGMENT_LSB +: 8];

  // Cache-use bit is read back and passed out on bootControl; no decoded pin follows it
  assign bootControl   = state_reg.bootCtrl;
  assign bootMirrorRom = (state_reg.bootCtrl[BOOT_MIRROR_LSB +: 2] == BOOT_MIRROR_ROM);
  assign dualCoreImage = (imageSelect == IMAGE_DUAL_CORE);

  // Audio resources are unused, so their inputs never leave the idle level
  assign audioInputs = AUDIO_INACTIVE[AUDIO_WIDTH-1:0];

endmodule
`default_nettype wire

//--- dv/bgs_gpio_properties.sv
// Checker of port, strap and audio behaviour at the top ports
`timescale 1ns/10ps
`default_nettype none
module bgs_gpio_properties
  import bgs_pkg::*;
#(
  parameter int         ADDR_WIDTH     = 16,
  parameter int         AUDIO_WIDTH    = 8,
  parameter logic [7:0] AUDIO_INACTIVE = 8'h00
)(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   srst,
  // Bus
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ADDR_WIDTH-1:0]  paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  // Pins
  input wire logic [7:0]             carrierLeds,
  input wire logic                   carrierIrq,
  input wire logic [3:0]             startButtons,
  input wire logic [AUDIO_WIDTH-1:0] audioInputs,
  input wire logic [7:0]             cardLeds,
  input wire logic [7:0]             segmentDrive,
  input wire logic [6:0]             cardJumpers,
  // Straps and boot state
  input wire logic [31:0]            dipBanks,
  input wire logic [1:0]             imageSelectSwitch,
  input wire logic [31:0]            bootControl,
  input wire logic                   bootMirrorRom,
  input wire logic [1:0]             imageSelect,
  input wire logic                   dualCoreImage
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  logic       wrA;
  logic       wrB;
  logic       rdA;
  logic       rdB;
  logic [7:0] ledPick;
  assign wrA = psel && penable && pwrite && pstrb == 4'hF && paddr == OFS_CARRIER_LED_OUT;
  assign wrB = psel && penable && pwrite && pstrb == 4'hF && paddr == OFS_CARD_OUT;
  // Input word flop, then read-data flop: the access edge sees pins from two edges back
  assign rdA = psel && !penable && !pwrite && paddr == OFS_CARRIER_IN;
  assign rdB = psel && !penable && !pwrite && paddr == OFS_CARD_IN;
  assign ledPick = {pwdata[16], pwdata[15], pwdata[11], pwdata[10], pwdata[6], pwdata[5], pwdata[1], pwdata[0]};
  ////////////////////////////////////////
  AST_AUDIO_IDLE: assert property (audioInputs == AUDIO_INACTIVE[AUDIO_WIDTH-1:0])
    else $error("audio input driven active");
  AST_LED_WRITE: assert property (wrA |=> carrierLeds == $past(ledPick))
    else $error("carrier LEDs do not follow write");
  AST_CARD_WRITE: assert property (wrB |=> {segmentDrive, cardLeds} == $past(pwdata[23:8]))
    else $error("card LEDs or segments do not follow write");
  AST_IRQ_BUTTONS: assert property (rdA |=> prdata[12] == $past(carrierIrq, 2) && prdata[23:20] ==
    {$past(startButtons[3], 2), $past(startButtons[1], 2), $past(startButtons[2], 2), $past(startButtons[0], 2)})
    else $error("carrier input word wrong");
  AST_IN_A_RSVD: assert property (rdA |=> (prdata & ~32'h00F0_1000) == '0)
    else $error("reserved carrier input bits set");
  AST_JUMPERS: assert property (rdB |=> prdata == {24'h0, $past(cardJumpers, 2), 1'b0})
    else $error("jumper input word wrong");
  AST_STRAP_LOAD: assert property ($fell(srst) |=> bootControl == $past(dipBanks, 2))
    else $error("boot control not loaded from straps");
  AST_IMAGE_LATCH: assert property ($fell(srst) |=> imageSelect == $past(imageSelectSwitch, 2) &&
    dualCoreImage == ($past(imageSelectSwitch, 2) == IMAGE_DUAL_CORE))
    else $error("image select latch wrong");
  AST_MIRROR: assert property (bootMirrorRom == (bootControl[9:8] == BOOT_MIRROR_ROM))
    else $error("boot mirror decode wrong");
endmodule
bind bgs_gpio_top bgs_gpio_properties #(.ADDR_WIDTH(ADDR_WIDTH), .AUDIO_WIDTH(AUDIO_WIDTH),
  .AUDIO_INACTIVE(AUDIO_INACTIVE)) bgs_gpio_properties_i (.ref_clk, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .carrierLeds, .carrierIrq, .startButtons, .audioInputs,
  .cardLeds, .segmentDrive, .cardJumpers, .dipBanks, .imageSelectSwitch, .bootControl,
  .bootMirrorRom, .imageSelect, .dualCoreImage);
`default_nettype wire

//--- dv/bgs_board_model.sv
// Carrier board and card: switches, buttons, jumpers and interrupt line
`timescale 1ns/10ps
`default_nettype none
module bgs_board_model (
  // Reset seen by the strap group
  input  wire logic        srst,
  // Settings chosen by the bench
  input  wire logic        irqSet,
  input  wire logic [3:0]  btnSet,
  input  wire logic [6:0]  jumperSet,
  input  wire logic [31:0] dipSet,
  input  wire logic [1:0]  imageSet,
  // Board pins
  output logic             carrierIrq,
  output logic      [3:0]  startButtons,
  output logic      [6:0]  cardJumpers,
  output logic      [31:0] dipBanks,
  output logic      [1:0]  imageSelectSwitch
);
  // DIP switches reach the group only in reset; after it other traffic shows, so a late capture is seen
  assign dipBanks          = srst ? dipSet : ~dipSet;
  assign imageSelectSwitch = imageSet;
  assign carrierIrq        = irqSet;
  assign startButtons      = btnSet;
  assign cardJumpers       = jumperSet;
endmodule
`default_nettype wire

//--- dv/tb_board_gpio_and_boot_strap_latch.sv
// Self-checking bench for the board GPIO and boot strap latch
`timescale 1ns/10ps
`default_nettype none
module tb_board_gpio_and_boot_strap_latch import bgs_pkg::*;;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic        carrierIrq, bootMirrorRom, dualCoreImage, irqSet;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, dipBanks, bootControl, dipSet, rd;
  logic [3:0]  pstrb, startButtons, btnSet;
  logic [7:0]  carrierLeds, audioInputs, cardLeds, segmentDrive;
  logic [6:0]  cardJumpers, jumperSet;
  logic [1:0]  imageSelectSwitch, imageSelect, imageSet;
  int          err_count, checked;
  bgs_gpio_top bgs_gpio_top_i (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .carrierLeds, .carrierIrq, .startButtons, .audioInputs, .cardLeds,
    .segmentDrive, .cardJumpers, .dipBanks, .imageSelectSwitch, .bootControl, .bootMirrorRom,
    .imageSelect, .dualCoreImage);
  bgs_board_model bgs_board_model_i (.srst, .irqSet, .btnSet, .jumperSet, .dipSet, .imageSet,
    .carrierIrq, .startButtons, .cardJumpers, .dipBanks, .imageSelectSwitch);
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Zero wait states, so the access edge is also the completion edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = s;
    @(posedge ref_clk);
    #1;
    penable = 1'b1;
    @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic run_straps();
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {16'h3C5A, 2'b00, i[0], 3'b000, i[1:0], 8'hA5};
      dipSet = d;
      imageSet = i[1:0];
      srst = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(bootControl, d);
      chk({imageSelect, dualCoreImage, bootMirrorRom}, {i[1:0], i == 1, i == 1});
      apb(1'b0, OFS_BOOT_CTRL, '0, 4'h0);
      chk(rd, d);
      apb(1'b0, OFS_STRAP_STATUS, '0, 4'h0);
      chk(rd, {26'h0, i[0], i == 1, i[1], i == 1, i[1:0]});
      chk(audioInputs, 8'h00);
    end
  endtask
  task automatic run_outputs();
    int b[8] = '{0, 1, 5, 6, 10, 11, 15, 16};
    apb(1'b1, OFS_CARRIER_LED_OUT, '1, 4'hF);
    chk(carrierLeds, 8'hFF);
    apb(1'b0, OFS_CARRIER_LED_OUT, '0, 4'h0);
    chk(rd, 32'h0001_8C63);
    apb(1'b1, OFS_CARRIER_LED_OUT, '0, 4'h1);
    chk(carrierLeds, 8'hF0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, OFS_CARRIER_LED_OUT, 32'h1 << b[k], 4'hF);
      chk(carrierLeds, 8'h1 << k);
    end
    apb(1'b1, OFS_CARD_OUT, '1, 4'hF);
    apb(1'b0, OFS_CARD_OUT, '0, 4'h0);
    chk(rd, 32'h00FF_FF00);
    apb(1'b1, OFS_CARD_OUT, 32'h00A5_3C00, 4'h6);
    chk({segmentDrive, cardLeds}, 16'hA53C);
    apb(1'b1, OFS_CARD_OUT, '0, 4'h4);
    chk({segmentDrive, cardLeds}, 16'h003C);
  endtask
  task automatic run_inputs();
    logic [3:0] bt;
    for (int k = 0; k < 5; k++) begin
      bt = 4'h1 << k;
      irqSet = k[0];
      btnSet = bt;
      jumperSet = 7'h55 ^ k[6:0];
      repeat (2) @(posedge ref_clk);
      apb(1'b0, OFS_CARRIER_IN, '0, 4'h0);
      chk(rd, {8'h0, bt[3], bt[1], bt[2], bt[0], 7'h0, k[0], 12'h0});
      apb(1'b0, OFS_CARD_IN, '0, 4'h0);
      chk(rd, {24'h0, jumperSet, 1'b0});
    end
    apb(1'b1, OFS_CARRIER_IN, '1, 4'hF);
    chk(er, 1'b0);
    apb(1'b0, 16'h3008, '0, 4'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    chk(pready, 1'b1);
    apb(1'b1, OFS_BOOT_CTRL, 32'h1234_5678, 4'hF);
    chk(bootControl, 32'h1234_5678);
    chk(bootMirrorRom, 1'b0);
    apb(1'b1, OFS_BOOT_CTRL, 32'h0000_0100, 4'h2);
    chk(bootMirrorRom, 1'b1);
  endtask
  ////////////////////////////////////////
  initial begin
    err_count = 0;
    checked = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    irqSet = 1'b0;
    btnSet = 4'h0;
    jumperSet = 7'h00;
    dipSet = '0;
    imageSet = 2'h0;
    run_straps();
    run_outputs();
    run_inputs();
    tally_and_finish();
  end
  // Full run is well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
